// ### rtl/dbm_mapper.sv
// Direct bank address mapper top
module dbm_mapper (
   input wire logic SYS_CLK_IN,
   input wire logic NRST_IN,
   input wire logic BANK_WR_IN,
   input wire logic [2:0] BANK_DATA_IN,
   input wire logic REQ_IN,
   input wire logic [1:0] KIND_IN,
   input wire logic [15:0] OPERAND_IN,
   input wire logic [2:0] GPR_BANK_IN,
   input wire logic [2:0] GPR_SEL_IN,
   input wire logic [4:0] VEC_SLOT_IN,
   input wire logic VEC_HIGH_IN,
   output logic VALID_OUT,
   output logic MAPPED_OUT,
   output logic [15:0] ADDR_OUT,
   output logic [3:0] REGION_OUT,
   output logic [2:0] BANK_OUT
);
   dbm_map_if map ();
   logic [2:0] direct_bank_pointer_reg;
   logic [15:0] addr_next;
   logic mapped_next;
   dbm_pkg::dbm_kind_e kind;

   assign kind = dbm_pkg::dbm_kind_e'(KIND_IN);

   dbm_region_dec u_dec (
      .map(map)
   );

   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         direct_bank_pointer_reg <= dbm_pkg::DBM_BANK_RESET;
      end else if (BANK_WR_IN) begin
         direct_bank_pointer_reg <= BANK_DATA_IN;
      end
   end

   always_comb begin
      addr_next = OPERAND_IN;
      mapped_next = 1'h1;
      case (kind)
         dbm_pkg::DBM_K_DIRECT: begin
            if (OPERAND_IN[7:0] <= dbm_pkg::DBM_IO_LAST[7:0]) begin
               addr_next = {8'h00, OPERAND_IN[7:0]};
            end else if (direct_bank_pointer_reg == 3'h0) begin
               addr_next = {8'h00, OPERAND_IN[7:0]};
               if (OPERAND_IN[7:0] <= dbm_pkg::DBM_HOLE_LAST[7:0]) begin
                  mapped_next = 1'h0;
               end
            end else begin
               addr_next = dbm_pkg::DBM_DIR_FIRST +
                  16'({direct_bank_pointer_reg, 7'h00}) +
                  {9'h000, OPERAND_IN[6:0]};
            end
         end
         dbm_pkg::DBM_K_GPR: begin
            addr_next = dbm_pkg::DBM_GPR_FIRST +
               {10'h000, GPR_BANK_IN, GPR_SEL_IN};
         end
         dbm_pkg::DBM_K_VECTOR: begin
            addr_next = dbm_pkg::DBM_VEC_FIRST +
               {10'h000, VEC_SLOT_IN, VEC_HIGH_IN};
         end
         default: begin
            addr_next = OPERAND_IN;
         end
      endcase
   end

   assign map.addr = addr_next;

   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         VALID_OUT <= 1'h0;
         MAPPED_OUT <= 1'h0;
         ADDR_OUT <= dbm_pkg::DBM_ADDR_RESET;
         REGION_OUT <= dbm_pkg::DBM_REGION_RESET;
      end else begin
         VALID_OUT <= REQ_IN;
         MAPPED_OUT <= REQ_IN && mapped_next;
         ADDR_OUT <= REQ_IN ? addr_next : ADDR_OUT;
         REGION_OUT <= REQ_IN ? map.region : REGION_OUT;
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge NRST_IN) begin
      if (!NRST_IN) begin
         BANK_OUT <= dbm_pkg::DBM_BANK_RESET;
      end else begin
         BANK_OUT <= BANK_WR_IN ? BANK_DATA_IN : direct_bank_pointer_reg;
      end
   end

   io_fixed_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      REQ_IN && kind == dbm_pkg::DBM_K_DIRECT && OPERAND_IN[7:0] < 8'h80
      |=> MAPPED_OUT && ADDR_OUT == {8'h00, $past(OPERAND_IN[7:0])})
      else $error("io operand moved by bank");

   bank_window_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      REQ_IN && kind == dbm_pkg::DBM_K_DIRECT && OPERAND_IN[7]
      && direct_bank_pointer_reg != 3'h0
      |=> ADDR_OUT[6:0] == $past(OPERAND_IN[6:0])
      && ADDR_OUT[10:7] == 4'($past(direct_bank_pointer_reg)) + 4'h1
      && ADDR_OUT[15:11] == 5'h00)
      else $error("bank window address wrong");

   bank_hole_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      REQ_IN && kind == dbm_pkg::DBM_K_DIRECT && OPERAND_IN[7:4] == 4'h8
      && direct_bank_pointer_reg == 3'h0
      |=> VALID_OUT && !MAPPED_OUT)
      else $error("bank zero hole mapped");

   gpr_region_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      REQ_IN && kind == dbm_pkg::DBM_K_GPR
      |=> REGION_OUT[dbm_pkg::DBM_R_GPR] && ADDR_OUT[15:8] == 8'h01)
      else $error("register form outside register area");

   vec_region_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      REQ_IN && kind == dbm_pkg::DBM_K_VECTOR
      |=> REGION_OUT == 4'h8 && ADDR_OUT[15:6] == 10'h3FF)
      else $error("vector fetch outside table");

   nvr_region_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      REQ_IN && kind == dbm_pkg::DBM_K_NORMAL
      && OPERAND_IN inside {[16'hFFBB:16'hFFBF]}
      |=> REGION_OUT == 4'h4)
      else $error("nvr area not decoded");

   req_valid_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      REQ_IN |=> VALID_OUT)
      else $error("request not answered");

   idle_quiet_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      !REQ_IN |=> !VALID_OUT && !MAPPED_OUT)
      else $error("answer without request");

   result_hold_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      !REQ_IN |=> $stable(ADDR_OUT) && $stable(REGION_OUT))
      else $error("result changed without request");

   bank_load_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      BANK_WR_IN |=> BANK_OUT == $past(BANK_DATA_IN)
      && direct_bank_pointer_reg == $past(BANK_DATA_IN))
      else $error("bank pointer not loaded");

   bank_keep_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      !BANK_WR_IN |=> $stable(direct_bank_pointer_reg)
      && BANK_OUT == direct_bank_pointer_reg)
      else $error("bank pointer changed without write");

   bank_pass_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      REQ_IN && kind == dbm_pkg::DBM_K_DIRECT
      && OPERAND_IN[7:0] > dbm_pkg::DBM_HOLE_LAST[7:0]
      && direct_bank_pointer_reg == 3'h0
      |=> MAPPED_OUT && ADDR_OUT == {8'h00, $past(OPERAND_IN[7:0])})
      else $error("bank zero operand moved");

   window_top_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      REQ_IN && kind == dbm_pkg::DBM_K_DIRECT && OPERAND_IN[7]
      && direct_bank_pointer_reg == 3'h7
      |=> ADDR_OUT >= 16'h0400 && ADDR_OUT <= 16'h047F)
      else $error("top bank window wrong");

   io_region_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      REQ_IN && kind == dbm_pkg::DBM_K_DIRECT && OPERAND_IN[7:0] < 8'h80
      |=> REGION_OUT == 4'h1)
      else $error("io operand not in io region");

   hole_region_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      REQ_IN && kind == dbm_pkg::DBM_K_DIRECT && OPERAND_IN[7:4] == 4'h8
      && direct_bank_pointer_reg == 3'h0
      |=> REGION_OUT == 4'h0 && ADDR_OUT[15:8] == 8'h00)
      else $error("bank zero hole decoded");

   other_mapped_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      REQ_IN && kind != dbm_pkg::DBM_K_DIRECT |=> MAPPED_OUT)
      else $error("non direct access unmapped");

   normal_pass_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      REQ_IN && kind == dbm_pkg::DBM_K_NORMAL
      |=> ADDR_OUT == $past(OPERAND_IN))
      else $error("normal address altered");

   gpr_index_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      REQ_IN && kind == dbm_pkg::DBM_K_GPR
      |=> ADDR_OUT[7:0] == {2'h0, $past(GPR_BANK_IN), $past(GPR_SEL_IN)})
      else $error("register form index wrong");

   vec_index_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      REQ_IN && kind == dbm_pkg::DBM_K_VECTOR
      |=> ADDR_OUT[5:0] == {$past(VEC_SLOT_IN), $past(VEC_HIGH_IN)})
      else $error("vector slot index wrong");

   region_onehot_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      $onehot0(REGION_OUT))
      else $error("more than one region decoded");

   direct_low_a: assert property (
      @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
      REQ_IN && kind == dbm_pkg::DBM_K_DIRECT
      |=> !REGION_OUT[dbm_pkg::DBM_R_NVR]
      && !REGION_OUT[dbm_pkg::DBM_R_VEC])
      else $error("direct operand reached flash area");
endmodule // dbm_mapper

// ### rtl/dbm_pkg.sv
// Constants and types for the direct bank address mapper
package dbm_pkg;
   localparam logic [2:0] DBM_BANK_RESET = 3'h0;
   localparam logic [15:0] DBM_IO_FIRST = 16'h0000;
   localparam logic [15:0] DBM_IO_LAST = 16'h007F;
   localparam logic [15:0] DBM_DIR_FIRST = 16'h0080;
   localparam logic [15:0] DBM_DIR_LAST = 16'h00FF;
   localparam logic [15:0] DBM_HOLE_LAST = 16'h008F;
   localparam logic [15:0] DBM_BANK_STEP = 16'h0080;
   localparam logic [15:0] DBM_GPR_FIRST = 16'h0100;
   localparam logic [15:0] DBM_GPR_LAST = 16'h01FF;
   localparam logic [15:0] DBM_NVR_FIRST = 16'hFFBB;
   localparam logic [15:0] DBM_NVR_LAST = 16'hFFBF;
   localparam logic [15:0] DBM_VEC_FIRST = 16'hFFC0;
   localparam logic [15:0] DBM_VEC_LAST = 16'hFFFF;
   localparam logic [15:0] DBM_ADDR_RESET = 16'h0000;
   localparam logic [3:0] DBM_REGION_RESET = 4'h0;
   // Region one-hot bits: io, gpr, nvr, vector
   localparam int DBM_R_IO = 0;
   localparam int DBM_R_GPR = 1;
   localparam int DBM_R_NVR = 2;
   localparam int DBM_R_VEC = 3;
   typedef enum logic [1:0] {
      DBM_K_NORMAL = 2'h0,
      DBM_K_DIRECT = 2'h1,
      DBM_K_GPR = 2'h3,
      DBM_K_VECTOR = 2'h2
   } dbm_kind_e;
endpackage : dbm_pkg

// ### rtl/dbm_map_if.sv
// Interface between the mapper top and its address decoder
interface dbm_map_if;
   logic [15:0] addr;
   logic [3:0] region;
   modport dec (input addr, output region);
   modport top (output addr, input region);
endinterface : dbm_map_if

// ### rtl/dbm_region_dec.sv
// Fixed region decoder for physical addresses
module dbm_region_dec (
   dbm_map_if.dec map
);
   function automatic logic in_range(input logic [15:0] a,
         input logic [15:0] lo, input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   always_comb begin
      map.region = '0;
      map.region[dbm_pkg::DBM_R_IO] = in_range(map.addr,
         dbm_pkg::DBM_IO_FIRST, dbm_pkg::DBM_IO_LAST);
      map.region[dbm_pkg::DBM_R_GPR] = in_range(map.addr,
         dbm_pkg::DBM_GPR_FIRST, dbm_pkg::DBM_GPR_LAST);
      map.region[dbm_pkg::DBM_R_NVR] = in_range(map.addr,
         dbm_pkg::DBM_NVR_FIRST, dbm_pkg::DBM_NVR_LAST);
      map.region[dbm_pkg::DBM_R_VEC] = in_range(map.addr,
         dbm_pkg::DBM_VEC_FIRST, dbm_pkg::DBM_VEC_LAST);
   end
endmodule // dbm_region_dec

// ### tb/dbm_cpu_model.sv
// CPU-side model that issues mapper requests
module dbm_cpu_model (
   input wire logic clk_in,
   output logic req_out,
   output logic wr_out,
   output logic [1:0] kind_out,
   output logic [15:0] op_out
);
   timeunit 1ns / 1ps;
   initial begin
      req_out = 1'h0;
      wr_out = 1'h0;
      kind_out = 2'h0;
      op_out = 16'h0;
   end
   task automatic issue(input logic [1:0] k, input logic [15:0] op);
      req_out <= 1'h1;
      kind_out <= k;
      op_out <= op;
      @(posedge clk_in);
      req_out <= 1'h0;
      op_out <= ~op;
   endtask
   task automatic set_bank(input logic [2:0] b);
      wr_out <= 1'h1;
      op_out <= 16'(b);
      @(posedge clk_in);
      wr_out <= 1'h0;
   endtask
endmodule // dbm_cpu_model

// ### tb/direct_bank_address_mapper_tb.sv
// Self-checking bench for the direct bank address mapper
module direct_bank_address_mapper_tb;
   timeunit 1ns / 1ps;
   logic clk = 1'h0, nrst = 1'h0, req, wr, valid, mapped;
   logic [15:0] op, addr;
   logic [3:0] hot;
   logic [1:0] kind;
   logic [2:0] bank;
   int num_errors = 0, num_checks = 0;
   always #4 clk = ~clk;
   dbm_cpu_model cpu (.clk_in(clk), .req_out(req), .wr_out(wr),
      .kind_out(kind), .op_out(op));
   dbm_mapper dut (.SYS_CLK_IN(clk), .NRST_IN(nrst), .BANK_WR_IN(wr),
      .BANK_DATA_IN(op[2:0]), .REQ_IN(req), .KIND_IN(kind), .OPERAND_IN(op),
      .GPR_BANK_IN(op[5:3]), .GPR_SEL_IN(op[2:0]), .VEC_SLOT_IN(op[5:1]),
      .VEC_HIGH_IN(op[0]), .VALID_OUT(valid), .MAPPED_OUT(mapped),
      .ADDR_OUT(addr), .REGION_OUT(hot), .BANK_OUT(bank));
   task automatic chk(input string n, input logic [19:0] s, e);
      num_checks++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic xfer(input logic [1:0] k, input logic [15:0] o,
         input logic m, input logic [19:0] e);
      cpu.issue(k, o);
      #1;
      chk("flags", 20'({valid, mapped}), 20'({1'h1, m}));
      if (m) chk("addr", {hot, addr}, e);
      @(posedge clk);
      #1 chk("idle", 20'({valid, mapped}), 20'h0);
      if (m) chk("hold", {hot, addr}, e);
      @(posedge clk);
   endtask
   task automatic t_fixed;
      chk("bank", 20'(bank), 20'h0);
      xfer(2'h1, 16'h00FF, 1'h1, 20'h000FF);
      xfer(2'h1, 16'h0088, 1'h0, 20'h0);
      xfer(2'h1, 16'h008F, 1'h0, 20'h0);
      xfer(2'h1, 16'h0090, 1'h1, 20'h00090);
      xfer(2'h0, 16'h0005, 1'h1, 20'h10005);
      xfer(2'h3, 16'h003F, 1'h1, 20'h2013F);
      xfer(2'h0, 16'h01A0, 1'h1, 20'h201A0);
      xfer(2'h2, 16'h003F, 1'h1, 20'h8FFFF);
      xfer(2'h2, 16'h0000, 1'h1, 20'h8FFC0);
      xfer(2'h0, 16'hFFBB, 1'h1, 20'h4FFBB);
      xfer(2'h0, 16'hFFBA, 1'h1, 20'h0FFBA);
   endtask
   task automatic t_banks;
      for (int b = 1; b < 8; b++) begin
         cpu.set_bank(3'(b));
         #1 chk("bank", 20'(bank), 20'(b));
         @(posedge clk);
         xfer(2'h1, 16'h0085, 1'h1,
            20'(b * 128 + 133) | ((b < 3) ? 20'h20000 : 20'h0));
         xfer(2'h1, 16'h007F, 1'h1, 20'h1007F);
      end
   endtask
   task automatic t_reset;
      nrst <= 1'h0;
      #1 chk("reset", {hot, addr}, 20'h0);
      chk("reset_bank", 20'({bank, valid, mapped}), 20'h0);
      @(posedge clk);
      nrst <= 1'h1;
      xfer(2'h1, 16'h0095, 1'h1, 20'h00095);
      xfer(2'h1, 16'h0080, 1'h0, 20'h0);
   endtask
   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'h1;
      t_fixed();
      t_banks();
      t_reset();
      close_out();
   end
   initial begin
      #20000 num_errors++;
      close_out();
   end
endmodule // direct_bank_address_mapper_tb
